// ==== hw/tec_pkg.sv ====
/*
 * Package for the timer/event counter block: constants, command codes and
 * carrier types shared by the counter core and its machine-cycle generator.
 * Assumes a single clock domain at the oscillator rate.
 */
package tec_pkg;

    // -----------------------------------------------------------------
    // Widths and timing
    // -----------------------------------------------------------------
    localparam int unsigned COUNT_W        = 8;
    localparam int unsigned PRESCALE_W     = 5;
    localparam int unsigned STATES_PER_MC  = 10;
    localparam int unsigned OSC_PER_STATE  = 3;
    localparam int unsigned OSC_PER_MC     = STATES_PER_MC * OSC_PER_STATE;
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned MC_PERIOD_NS   = OSC_PER_MC * CLK_PERIOD_NS;

    // -----------------------------------------------------------------
    // Status word layout and reset values
    // -----------------------------------------------------------------
    localparam int unsigned PSW_BYPASS_BIT = 3;
    localparam int unsigned PSW_UNUSED_BIT = 5;
    localparam logic [7:0]  PSW_RESET      = 8'h20;
    localparam logic [7:0]  COUNT_RESET    = 8'h00;
    localparam logic [4:0]  PRESCALE_RESET = 5'h00;
    localparam logic [4:0]  PRESCALE_MAX   = 5'h1f;
    localparam logic [7:0]  COUNT_MAX      = 8'hff;

    // -----------------------------------------------------------------
    // Command codes presented on the command port
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        TEC_CMD_NONE        = 4'h0,
        TEC_CMD_LOAD_COUNT  = 4'h1,
        TEC_CMD_READ_COUNT  = 4'h2,
        TEC_CMD_START_EVENT = 4'h3,
        TEC_CMD_START_TIMER = 4'h4,
        TEC_CMD_STOP        = 4'h5,
        TEC_CMD_IRQ_ENABLE  = 4'h6,
        TEC_CMD_IRQ_DISABLE = 4'h7,
        TEC_CMD_PSW_WRITE   = 4'h8,
        TEC_CMD_PSW_READ    = 4'h9,
        TEC_CMD_TEST_FLAG   = 4'ha
    } tec_cmd_t;

    // Run mode of the counter
    typedef enum logic [1:0] {
        TEC_MODE_STOPPED = 2'b00,
        TEC_MODE_TIMER   = 2'b01,
        TEC_MODE_EVENT   = 2'b10
    } tec_mode_t;

    // Command request: code plus accumulator data
    typedef struct packed {
        tec_cmd_t  code;
        logic [7:0] acc;
    } tec_req_t;

    // Answer returned to the accumulator
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } tec_rsp_t;

endpackage

// ==== hw/tec_mcycle.sv ====
/*
 * Machine-cycle generator: divides the oscillator clock into states and
 * states into machine cycles, pulsing once per machine cycle.
 * Assumes CLK_I is the oscillator and RESET_I is synchronous, active high.
 */
module tec_mcycle
    import tec_pkg::*;
#(
    parameter int unsigned STATES    = STATES_PER_MC,
    parameter int unsigned PER_STATE = OSC_PER_STATE
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    output logic      mc_tick_o
);

    localparam int unsigned SW = $clog2(PER_STATE + 1);
    localparam int unsigned NW = $clog2(STATES + 1);

    // Refuse divisors below one
    initial begin
        if (STATES < 1 || PER_STATE < 1) begin
            $error("tec_mcycle: divisors must be at least one");
        end
    end

    logic [SW-1:0] osc_cnt_r;
    logic [NW-1:0] state_cnt_r;
    wire           state_end = (osc_cnt_r == SW'(PER_STATE - 1));
    wire           cycle_end = state_end && (state_cnt_r == NW'(STATES - 1));

    // Oscillator periods within a state, states within a cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            osc_cnt_r   <= '0;
            state_cnt_r <= '0;
            mc_tick_o   <= 1'b0;
        end else begin
            osc_cnt_r   <= state_end ? '0 : osc_cnt_r + SW'(1);
            if (state_end) begin
                state_cnt_r <= cycle_end ? '0 : state_cnt_r + NW'(1);
            end
            mc_tick_o   <= cycle_end;
        end
    end

endmodule

// ==== hw/tec_top.sv ====
/*
 * Timer/event counter with its prescaler, overflow flag, counter interrupt
 * enable and the writable prescale bit of the status word.
 * Assumes the CPU presents one command per clock on CMD_I and that the
 * event input arrives asynchronously from a pin.
 */
// What this block does
// - Counter is an eight-bit register that only counts upward.
// - Timer mode counts prescaler overflow (cycles/32) or each machine cycle.
// - Event mode increments once per low-to-high transition on event input.
// - Counter advances at most once per cycle; source keeps edges that slow.
// - Each positive event increments; overflow sets the overflow flag.
// - Machine cycle is ten states of three oscillator periods each.
// - Status bit 3 clear divides by 32, set bypasses prescaler.
// - Whole status word readable; only bit 3 writable from accumulator bit 3.
// - Rising reset input starts the reset actions.
// - Reset stops the counter and clears its count to zero in the same cycle.
// - Reset returns prescale selection to divide by 32.
// - Reset clears the overflow flag.
// - Reset disables external, timer and serial interrupt sources.
// - Counter loads from and copies to accumulator in one cycle.
// - Separate commands start event mode, start timer mode, stop counter.
// - Commands enable and disable counter interrupt independently.
module tec_top
    import tec_pkg::*;
#(
    parameter int unsigned PRESCALE_BITS = PRESCALE_W
) (
    input  wire logic              CLK_I,
    input  wire logic              RESET_I,
    input  wire tec_pkg::tec_req_t CMD_I,
    input  wire logic              EVENT_INPUT_I,
    input  wire logic [2:0]        STACK_PTR_I,
    input  wire logic              BANK_SEL_I,
    input  wire logic              AUX_CARRY_I,
    input  wire logic              CARRY_I,
    output tec_pkg::tec_rsp_t      RSP_O,
    output logic [7:0]             COUNT_O,
    output logic                   COUNTER_OVERFLOW_FLAG_O,
    output logic                   PRESCALE_BYPASS_O,
    output logic                   COUNTER_IRQ_ENABLE_O,
    output logic                   COUNTER_IRQ_O,
    output logic                   IRQ_SOURCES_CLEAR_O,
    output tec_pkg::tec_mode_t     MODE_O
);
    import tec_pkg::*;

    // Refuse a prescaler width other than the one the divide-by-32 needs
    initial begin
        if (PRESCALE_BITS != PRESCALE_W) begin
            $error("tec_top: prescaler must be five bits wide");
        end
    end

    // -----------------------------------------------------------------
    // Machine cycle
    // -----------------------------------------------------------------
    logic mc_tick;

    // Ten states of three oscillator periods each
    tec_mcycle #(
        .STATES    (STATES_PER_MC),
        .PER_STATE (OSC_PER_STATE)
    ) u_mcycle (
        .clk_i     (CLK_I),
        .reset_i   (RESET_I),
        .mc_tick_o (mc_tick)
    );

    // -----------------------------------------------------------------
    // Event input synchroniser and edge detector
    // -----------------------------------------------------------------
    logic ev_meta_r;
    logic ev_sync_r;
    logic ev_prev_r;
    logic ev_pending_r;

    // Two flops before use, then a third for the previous sample
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            ev_meta_r <= 1'b0;
            ev_sync_r <= 1'b0;
            ev_prev_r <= 1'b0;
        end else begin
            ev_meta_r <= EVENT_INPUT_I;
            ev_sync_r <= ev_meta_r;
            ev_prev_r <= ev_sync_r;
        end
    end

    // Reset loads the idle low level, so no false edge follows reset
    wire ev_rise = ev_sync_r & ~ev_prev_r;

    // -----------------------------------------------------------------
    // Command decode
    // -----------------------------------------------------------------
    wire cmd_load   = (CMD_I.code == TEC_CMD_LOAD_COUNT);
    wire cmd_read   = (CMD_I.code == TEC_CMD_READ_COUNT);
    wire cmd_sevent = (CMD_I.code == TEC_CMD_START_EVENT);
    wire cmd_stimer = (CMD_I.code == TEC_CMD_START_TIMER);
    wire cmd_stop   = (CMD_I.code == TEC_CMD_STOP);
    wire cmd_irq_en = (CMD_I.code == TEC_CMD_IRQ_ENABLE);
    wire cmd_irq_ds = (CMD_I.code == TEC_CMD_IRQ_DISABLE);
    wire cmd_pswwr  = (CMD_I.code == TEC_CMD_PSW_WRITE);
    wire cmd_pswrd  = (CMD_I.code == TEC_CMD_PSW_READ);
    wire cmd_test   = (CMD_I.code == TEC_CMD_TEST_FLAG);

    // -----------------------------------------------------------------
    // State registers
    // -----------------------------------------------------------------
    tec_mode_t        mode_r;
    tec_mode_t        mode_nxt;
    logic [7:0]       count_r;
    logic [7:0]       count_nxt;
    logic [4:0]       prescale_r;
    logic [4:0]       prescale_nxt;
    logic             bypass_r;
    logic             flag_r;
    logic             flag_nxt;
    logic             irq_en_r;
    logic             irq_r;
    logic             irq_nxt;
    logic             ev_pending_nxt;
    tec_rsp_t         rsp_r;
    tec_rsp_t         rsp_nxt;

    // -----------------------------------------------------------------
    // Counting source selection
    // -----------------------------------------------------------------
    wire        timer_run   = (mode_r == TEC_MODE_TIMER);
    wire        event_run   = (mode_r == TEC_MODE_EVENT);
    wire        pre_wrap    = mc_tick && (prescale_r == PRESCALE_MAX);
    // Bypass set counts each machine cycle, clear counts cycles/32
    wire        timer_inc   = timer_run && (bypass_r ? mc_tick : pre_wrap);
    // Events held until the next machine cycle: one increment per cycle
    wire        event_inc   = event_run && mc_tick && (ev_pending_r || ev_rise);
    wire        count_inc   = timer_inc || event_inc;
    // A load in the wrapping cycle replaces the wrap, so it raises no flag
    wire        overflow    = count_inc && !cmd_load && (count_r == COUNT_MAX);

    // -----------------------------------------------------------------
    // Status word assembly
    // -----------------------------------------------------------------
    // Bit 5 has no function and always reads as one; only bit 3 lives here
    wire        psw_fixed_one = PSW_RESET[PSW_UNUSED_BIT];
    wire [7:0]  psw_value     = {CARRY_I, AUX_CARRY_I, psw_fixed_one, BANK_SEL_I,
                                 bypass_r, STACK_PTR_I};

    // Mode transitions from the start and stop commands
    always_comb begin
        mode_nxt = mode_r;
        case (1'b1)
            cmd_sevent: mode_nxt = TEC_MODE_EVENT;
            cmd_stimer: mode_nxt = TEC_MODE_TIMER;
            cmd_stop:   mode_nxt = TEC_MODE_STOPPED;
            default:    mode_nxt = mode_r;
        endcase
    end

    // Prescaler runs on machine cycles while the timer runs
    // A fresh start restarts it, so the first divided period is a full one
    always_comb begin
        prescale_nxt = prescale_r;
        if (cmd_stimer && !timer_run) begin
            prescale_nxt = PRESCALE_RESET;
        end else if (timer_run && mc_tick) begin
            prescale_nxt = prescale_r + 5'h01;
        end
    end

    // Count: load wins over increment, increments wrap past all ones
    always_comb begin
        count_nxt = count_r;
        if (cmd_load) begin
            count_nxt = CMD_I.acc;
        end else if (count_inc) begin
            count_nxt = count_r + 8'h01;
        end
    end

    // Event latched between machine cycles; cleared when consumed
    always_comb begin
        ev_pending_nxt = ev_pending_r;
        if (!event_run || mc_tick) begin
            ev_pending_nxt = 1'b0;
        end
        if (event_run && ev_rise && !mc_tick) begin
            ev_pending_nxt = 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // Overflow flag and interrupt request
    // -----------------------------------------------------------------
    // Overflow flag: set wins over the clear by testing it
    always_comb begin
        flag_nxt = flag_r;
        if (cmd_test) begin
            flag_nxt = 1'b0;
        end
        if (overflow) begin
            flag_nxt = 1'b1;
        end
    end

    // Interrupt request: enabled overflow sets, a disable or a clear enable clears
    // A disable in the overflow cycle wins, so a masked source never requests
    always_comb begin
        irq_nxt = irq_r;
        if (cmd_irq_ds || !irq_en_r) begin
            irq_nxt = 1'b0;
        end
        if (overflow && irq_en_r && !cmd_irq_ds) begin
            irq_nxt = 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // Accumulator answers
    // -----------------------------------------------------------------
    // Answers to the accumulator, one cycle after the command
    always_comb begin
        rsp_nxt = '0;
        if (cmd_read) begin
            rsp_nxt.valid = 1'b1;
            rsp_nxt.data  = count_r;
        end else if (cmd_pswrd) begin
            rsp_nxt.valid = 1'b1;
            rsp_nxt.data  = psw_value;
        end else if (cmd_test) begin
            rsp_nxt.valid = 1'b1;
            rsp_nxt.data  = {7'h00, flag_r};
        end
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    // Reset stops, clears count, flag, prescale select and enables
    // Only bit 3 of the status word is stored; the CPU keeps the others
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            mode_r       <= TEC_MODE_STOPPED;
            count_r      <= COUNT_RESET;
            prescale_r   <= PRESCALE_RESET;
            bypass_r     <= PSW_RESET[PSW_BYPASS_BIT];
            flag_r       <= 1'b0;
            irq_en_r     <= 1'b0;
            irq_r        <= 1'b0;
            ev_pending_r <= 1'b0;
            rsp_r        <= '0;
        end else begin
            mode_r       <= mode_nxt;
            count_r      <= count_nxt;
            prescale_r   <= prescale_nxt;
            flag_r       <= flag_nxt;
            irq_r        <= irq_nxt;
            ev_pending_r <= ev_pending_nxt;
            rsp_r        <= rsp_nxt;
            if (cmd_pswwr) begin
                bypass_r <= CMD_I.acc[PSW_BYPASS_BIT];
            end
            if (cmd_irq_en) begin
                irq_en_r <= 1'b1;
            end else if (cmd_irq_ds) begin
                irq_en_r <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // Reset broadcast
    // -----------------------------------------------------------------
    // Tells the external and serial sources to disable while reset stands;
    // no reset branch, since it must follow the reset itself
    always_ff @(posedge CLK_I) begin
        IRQ_SOURCES_CLEAR_O <= RESET_I;
    end

    // Output copies, each straight from a flop
    // Each copy takes the next-state value, so it equals its register every cycle
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            COUNT_O                 <= COUNT_RESET;
            COUNTER_OVERFLOW_FLAG_O <= 1'b0;
            PRESCALE_BYPASS_O       <= PSW_RESET[PSW_BYPASS_BIT];
            COUNTER_IRQ_ENABLE_O    <= 1'b0;
            COUNTER_IRQ_O           <= 1'b0;
            MODE_O                  <= TEC_MODE_STOPPED;
            RSP_O                   <= '0;
        end else begin
            COUNT_O                 <= count_nxt;
            COUNTER_OVERFLOW_FLAG_O <= flag_nxt;
            PRESCALE_BYPASS_O       <= cmd_pswwr ? CMD_I.acc[PSW_BYPASS_BIT] : bypass_r;
            COUNTER_IRQ_ENABLE_O    <= cmd_irq_en | (irq_en_r & ~cmd_irq_ds);
            COUNTER_IRQ_O           <= irq_nxt;
            MODE_O                  <= mode_nxt;
            RSP_O                   <= rsp_nxt;
        end
    end

endmodule

// ==== dv/tec_top_props.sv ====
/*
 * Port checker for the timer/event counter.
 * Assumes it is bound onto tec_top; one clock, reset synchronous active high.
 */
module tec_top_props
    import tec_pkg::*;
#(
    parameter int unsigned PRESCALE_BITS = PRESCALE_W
) (
    input wire logic               CLK_I,
    input wire logic               RESET_I,
    input wire tec_pkg::tec_req_t  CMD_I,
    input wire logic               EVENT_INPUT_I,
    input wire logic [2:0]         STACK_PTR_I,
    input wire logic               BANK_SEL_I,
    input wire logic               AUX_CARRY_I,
    input wire logic               CARRY_I,
    input wire tec_pkg::tec_rsp_t  RSP_O,
    input wire logic [7:0]         COUNT_O,
    input wire logic               COUNTER_OVERFLOW_FLAG_O,
    input wire logic               PRESCALE_BYPASS_O,
    input wire logic               COUNTER_IRQ_ENABLE_O,
    input wire logic               COUNTER_IRQ_O,
    input wire logic               IRQ_SOURCES_CLEAR_O,
    input wire tec_pkg::tec_mode_t MODE_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK_I); endclocking

    // Commands that must answer on the response port
    wire is_read = CMD_I.code inside {TEC_CMD_READ_COUNT, TEC_CMD_PSW_READ, TEC_CMD_TEST_FLAG};

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_reset_clears: assert property (RESET_I |=> COUNT_O == 8'h00
        && !COUNTER_OVERFLOW_FLAG_O && !PRESCALE_BYPASS_O && !COUNTER_IRQ_ENABLE_O
        && MODE_O == TEC_MODE_STOPPED)
        else $error("state not cleared by reset");
    a_sources_clear: assert property (1 |=> IRQ_SOURCES_CLEAR_O == $past(RESET_I))
        else $error("interrupt source clear does not follow reset");
    a_answer_pulse: assert property (disable iff (RESET_I)
        1 |=> RSP_O.valid == $past(is_read))
        else $error("answer valid does not match read command");
    a_count_read: assert property (disable iff (RESET_I)
        CMD_I.code == TEC_CMD_READ_COUNT |=> RSP_O.data == $past(COUNT_O))
        else $error("count read returns wrong data");
    a_status_read: assert property (disable iff (RESET_I)
        CMD_I.code == TEC_CMD_PSW_READ |=>
        RSP_O.data == {$past(CARRY_I), $past(AUX_CARRY_I), 1'b1, $past(BANK_SEL_I),
        $past(PRESCALE_BYPASS_O), $past(STACK_PTR_I)})
        else $error("status word read wrong");
    a_bypass_write: assert property (disable iff (RESET_I)
        $changed(PRESCALE_BYPASS_O) |->
        $past(CMD_I.code) == TEC_CMD_PSW_WRITE && PRESCALE_BYPASS_O == $past(CMD_I.acc[3]))
        else $error("prescale bit changed without status write");
    a_load_count: assert property (disable iff (RESET_I)
        CMD_I.code == TEC_CMD_LOAD_COUNT |=> COUNT_O == $past(CMD_I.acc))
        else $error("count not loaded from accumulator");
    a_count_step: assert property (disable iff (RESET_I) COUNT_O != $past(COUNT_O) &&
        $past(CMD_I.code) != TEC_CMD_LOAD_COUNT |-> COUNT_O == $past(COUNT_O) + 8'h01)
        else $error("count moved other than by one upward");
    a_wrap_flag: assert property (disable iff (RESET_I) $past(COUNT_O) == 8'hff &&
        COUNT_O == 8'h00 && $past(CMD_I.code) != TEC_CMD_LOAD_COUNT |->
        COUNTER_OVERFLOW_FLAG_O && (COUNTER_IRQ_O || !COUNTER_IRQ_ENABLE_O))
        else $error("overflow without flag or request");
    a_stop_holds: assert property (disable iff (RESET_I) MODE_O == TEC_MODE_STOPPED &&
        CMD_I.code != TEC_CMD_LOAD_COUNT |=> $stable(COUNT_O))
        else $error("stopped counter moved");
    a_start_modes: assert property (disable iff (RESET_I)
        (CMD_I.code == TEC_CMD_START_EVENT |=> MODE_O == TEC_MODE_EVENT) and
        (CMD_I.code == TEC_CMD_START_TIMER |=> MODE_O == TEC_MODE_TIMER))
        else $error("start command did not set mode");
    a_irq_disable: assert property (disable iff (RESET_I)
        CMD_I.code == TEC_CMD_IRQ_DISABLE
        |=> !COUNTER_IRQ_ENABLE_O ##0 !COUNTER_IRQ_O ##1 !COUNTER_IRQ_O)
        else $error("request survives disable");

    // Main scenarios reached
    c_overflow: cover property ($past(COUNT_O) == 8'hff && COUNT_O == 8'h00);
    c_event_mode: cover property (MODE_O == TEC_MODE_EVENT && $changed(COUNT_O));
    c_status_read: cover property (CMD_I.code == TEC_CMD_PSW_READ ##1 RSP_O.valid);
endmodule

// ==== dv/tec_event_src.sv ====
/*
 * Pulse source standing at the event input.
 * Assumes it is driven from the bench clock; the line idles low.
 */
module tec_event_src (
    input  wire logic clk_i,
    output logic      event_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial event_o = 1'b0;

    // Rises spaced by hi plus lo plus one clocks, kept above one machine cycle
    task automatic pulses(input int n, input int hi, input int lo);
        repeat (n) begin
            @(posedge clk_i);
            event_o <= 1'b1;
            repeat (hi) @(posedge clk_i);
            event_o <= 1'b0;
            repeat (lo) @(posedge clk_i);
        end
    endtask
endmodule

// ==== dv/tb_timer_event_counter.sv ====
/*
 * Self-checking bench for the timer/event counter.
 * Assumes a 10 MHz clock and the event source model beside the design.
 */
module tb_timer_event_counter;
    timeunit 1ns;
    timeprecision 1ns;
    import tec_pkg::*;

    logic      CLK_I, RESET_I, BANK_SEL_I, AUX_CARRY_I, CARRY_I, EVENT_INPUT_I;
    logic [2:0] STACK_PTR_I;
    tec_req_t  CMD_I;
    tec_rsp_t  RSP_O;
    logic [7:0] COUNT_O;
    logic      flag, bypass, irq_en, irq, src_clear;
    tec_mode_t MODE_O;
    int        miscompares = 0;
    int        checked = 0;
    int        cycles = 0;

    tec_top tec_top_i (.CLK_I(CLK_I), .RESET_I(RESET_I), .CMD_I(CMD_I),
        .EVENT_INPUT_I(EVENT_INPUT_I), .STACK_PTR_I(STACK_PTR_I), .BANK_SEL_I(BANK_SEL_I),
        .AUX_CARRY_I(AUX_CARRY_I), .CARRY_I(CARRY_I), .RSP_O(RSP_O), .COUNT_O(COUNT_O),
        .COUNTER_OVERFLOW_FLAG_O(flag), .PRESCALE_BYPASS_O(bypass),
        .COUNTER_IRQ_ENABLE_O(irq_en), .COUNTER_IRQ_O(irq),
        .IRQ_SOURCES_CLEAR_O(src_clear), .MODE_O(MODE_O));
    tec_event_src tec_event_src_i (.clk_i(CLK_I), .event_o(EVENT_INPUT_I));

    // ------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        CLK_I = 1'b0;
        forever #50 CLK_I = ~CLK_I;
    end

    // Cut a hang short
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask

    // One command, taken at the second edge
    task automatic cmd(input tec_cmd_t code, input logic [7:0] acc);
        @(posedge CLK_I);
        CMD_I <= '{code, acc};
        @(posedge CLK_I);
        CMD_I <= '{TEC_CMD_NONE, 8'h00};
        #1;
    endtask

    task automatic rd(input tec_cmd_t code, input logic [7:0] exp, input logic [7:0] msk);
        cmd(code, 8'h00);
        chk({7'h00, RSP_O.valid}, 8'h01);
        chk(RSP_O.data & msk, exp);
    endtask

    task automatic wait_cnt(input logic [7:0] exp, input int bound);
        repeat (bound) if (COUNT_O !== exp) idle(1);
        chk(COUNT_O, exp);
    endtask

    // Reset stands at n edges after the first, and at the releasing edge too
    task automatic do_reset(input int n);
        @(posedge CLK_I);
        RESET_I <= 1'b1;
        idle(n);
        chk(COUNT_O, 8'h00);
        chk({4'h0, flag, bypass, irq_en, irq}, 8'h00);
        chk({6'h00, MODE_O}, 8'h00);
        chk({7'h00, src_clear}, 8'h01);
        @(posedge CLK_I);
        RESET_I <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        RESET_I = 1'b1;
        CMD_I = '{TEC_CMD_NONE, 8'h00};
        STACK_PTR_I = 3'h5;
        BANK_SEL_I = 1'b1;
        AUX_CARRY_I = 1'b0;
        CARRY_I = 1'b1;
        do_reset(2);
        rd(TEC_CMD_PSW_READ, 8'hb5, 8'hff);
        chk({7'h00, src_clear}, 8'h00);
        cmd(TEC_CMD_PSW_WRITE, 8'hf7);
        chk({7'h00, bypass}, 8'h00);
        cmd(TEC_CMD_PSW_WRITE, 8'h08);
        rd(TEC_CMD_PSW_READ, 8'hbd, 8'hff);
        cmd(TEC_CMD_LOAD_COUNT, 8'h5a);
        idle(90);
        rd(TEC_CMD_READ_COUNT, 8'h5a, 8'hff);
        $display("status word and load test done");
        cmd(TEC_CMD_IRQ_ENABLE, 8'h00);
        chk({7'h00, irq_en}, 8'h01);
        cmd(TEC_CMD_LOAD_COUNT, 8'hfe);
        cmd(TEC_CMD_START_TIMER, 8'h00);
        chk({6'h00, MODE_O}, 8'h01);
        wait_cnt(8'hff, 40);
        idle(25);
        chk(COUNT_O, 8'hff);
        wait_cnt(8'h00, 10);
        chk({6'h00, flag, irq}, 8'h03);
        rd(TEC_CMD_TEST_FLAG, 8'h01, 8'h01);
        chk({7'h00, flag}, 8'h00);
        wait_cnt(8'h01, 40);
        cmd(TEC_CMD_IRQ_DISABLE, 8'h00);
        chk({6'h00, irq_en, irq}, 8'h00);
        cmd(TEC_CMD_STOP, 8'h00);
        chk({6'h00, MODE_O}, 8'h00);
        $display("bypass timer test done");
        cmd(TEC_CMD_PSW_WRITE, 8'h00);
        cmd(TEC_CMD_LOAD_COUNT, 8'h00);
        cmd(TEC_CMD_START_TIMER, 8'h00);
        idle(925);
        chk(COUNT_O, 8'h00);
        wait_cnt(8'h01, 40);
        cmd(TEC_CMD_PSW_WRITE, 8'h08);
        do_reset(62);
        $display("prescaled timer and reset test done");
        cmd(TEC_CMD_START_EVENT, 8'h00);
        chk({6'h00, MODE_O}, 8'h02);
        tec_event_src_i.pulses(5, 40, 40);
        idle(60);
        chk(COUNT_O, 8'h05);
        cmd(TEC_CMD_STOP, 8'h00);
        tec_event_src_i.pulses(2, 40, 40);
        chk(COUNT_O, 8'h05);
        $display("event counter test done");
        results();
    end
endmodule

bind tec_top tec_top_props #(.PRESCALE_BITS(PRESCALE_BITS)) tec_top_props_i (.*);
